// file: bdrv_defs.svh
// Purpose: named constants for the bridge driver register and control block
// Assumes: 16-bit serial frames, address in the top nibble, parity in bit 0
// Notes:   included by bare name
`ifndef BDRV_DEFS_SVH
`define BDRV_DEFS_SVH

`define BDRV_FRAME_BITS  5'h10
`define BDRV_ADDR_MSB    15
`define BDRV_ADDR_LSB    12
`define BDRV_WR_BIT      11
`define BDRV_ADDR_DIAG0  4'hC
`define BDRV_ADDR_DIAG1  4'hD
`define BDRV_ADDR_DIAG2  4'hE
`define BDRV_ADDR_CTRL   4'hF
`define BDRV_ADDR_NONE   4'h0

// control register fields
`define BDRV_DG_MSB      10
`define BDRV_DG_LSB      9
`define BDRV_DBM_BIT     8
`define BDRV_ESF_BIT     7
`define BDRV_BH_BIT      4
`define BDRV_BL_BIT      3
`define BDRV_AH_BIT      2
`define BDRV_AL_BIT      1
`define BDRV_CTRL_MASK   16'h079E
`define BDRV_CTRL_DRVMSK 16'h001E
`define BDRV_CTRL_RST    16'h0080

// diagnostic register fields
`define BDRV_D0_V3O      10
`define BDRV_D0_V3U      9
`define BDRV_D0_BHU      4
`define BDRV_D0_BLU      3
`define BDRV_D0_AHU      2
`define BDRV_D0_ALU      1
`define BDRV_D1_VRO      10
`define BDRV_D1_VRU      9
`define BDRV_D1_BHO      4
`define BDRV_D1_BLO      3
`define BDRV_D1_AHO      2
`define BDRV_D1_ALO      1
`define BDRV_D2_VSO      10
`define BDRV_D2_VSU      9
`define BDRV_D2_VB       7
`define BDRV_D2_VA       6
`define BDRV_D2_OCB      3
`define BDRV_D2_OCA      2
`define BDRV_D2_OL       1

// status word fields
`define BDRV_ST_FF       15
`define BDRV_ST_POR      14
`define BDRV_ST_SE       13
`define BDRV_ST_OT       11
`define BDRV_ST_TW       10
`define BDRV_ST_VS       9
`define BDRV_ST_VLO      8
`define BDRV_ST_ETO      7
`define BDRV_ST_VR       6
`define BDRV_ST_V3       5
`define BDRV_ST_LDF      4
`define BDRV_ST_BSU      3
`define BDRV_ST_GSU      2
`define BDRV_ST_DSO      1

// timing
`define BDRV_CLK_NS      4
`define BDRV_PULSE_NS    1000
`define BDRV_PULSE_CYC   ((`BDRV_PULSE_NS + `BDRV_CLK_NS - 1) / `BDRV_CLK_NS)
`define BDRV_PCNT_W      9

`endif

// file: bdrv_pkg.sv
// Purpose: shared types of the bridge driver register and control block
// Assumes: constants live in bdrv_defs.svh
// Notes:   no imports, use bdrv_pkg::name
package bdrv_pkg;

   typedef enum logic [1:0] {
      BDRV_DG_FAULT = 2'b00,
      BDRV_DG_PULSE = 2'b01,
      BDRV_DG_TEMP  = 2'b10,
      BDRV_DG_SENSE = 2'b11
   } bdrv_dgsel_t;

   typedef enum logic [1:0] {
      BDRV_PH_OFF  = 2'b00,
      BDRV_PH_HIGH = 2'b01,
      BDRV_PH_LOW  = 2'b10,
      BDRV_PH_DEAD = 2'b11
   } bdrv_phase_st_t;

endpackage : bdrv_pkg

// file: bdrv_deadtime.sv
// Purpose: one bridge phase, keeps high and low gates apart by a dead time
// Assumes: requests are synchronous to clk
// Notes:   both requests at once keep both gates off
`timescale 1ns/1ps
`include "bdrv_defs.svh"
module bdrv_deadtime (
   input  wire logic       clk,        // system clock
   input  wire logic       rst_n,      // async reset, active low
   input  wire logic       ce,         // clock enable
   input  wire logic       hi_req,     // high-side on request
   input  wire logic       lo_req,     // low-side on request
   input  wire logic [7:0] dead_cyc,   // dead time in clock cycles
   output logic            hi_gate,    // high-side gate drive
   output logic            lo_gate     // low-side gate drive
);
   bdrv_pkg::bdrv_phase_st_t st_r;
   bdrv_pkg::bdrv_phase_st_t st_nxt;
   logic [7:0]               cnt_r;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         bdrv_pkg::BDRV_PH_OFF: begin
            if (hi_req && !lo_req) st_nxt = bdrv_pkg::BDRV_PH_HIGH;
            else if (lo_req && !hi_req) st_nxt = bdrv_pkg::BDRV_PH_LOW;
         end
         bdrv_pkg::BDRV_PH_HIGH: begin
            if (!hi_req || lo_req) st_nxt = bdrv_pkg::BDRV_PH_DEAD;
         end
         bdrv_pkg::BDRV_PH_LOW: begin
            if (!lo_req || hi_req) st_nxt = bdrv_pkg::BDRV_PH_DEAD;
         end
         bdrv_pkg::BDRV_PH_DEAD: begin
            if (cnt_r == 8'h00) st_nxt = bdrv_pkg::BDRV_PH_OFF;
         end
         default: st_nxt = bdrv_pkg::BDRV_PH_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= bdrv_pkg::BDRV_PH_OFF;
         hi_gate <= 1'b0;
         lo_gate <= 1'b0;
      end else if (ce) begin
         st_r    <= st_nxt;
         hi_gate <= (st_nxt == bdrv_pkg::BDRV_PH_HIGH);
         lo_gate <= (st_nxt == bdrv_pkg::BDRV_PH_LOW);
      end
   end

   // counter reloads on entry to dead state, so every turn-off pays the full time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
      end else if (ce) begin
         if (st_r != bdrv_pkg::BDRV_PH_DEAD) cnt_r <= dead_cyc;
         else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule : bdrv_deadtime

// file: bdrv_regs.sv
// Purpose: serial register bank, status word and bridge gate logic of the driver
// Assumes: host is serial master, mode 0, msb first, 16-bit frames under strobe_n
// Notes:   all serial, fault, signal and bridge input pins pass a two-flop synchroniser; dead_cyc does not; serial clock is oversampled
`timescale 1ns/1ps
`include "bdrv_defs.svh"
module bdrv_regs (
   input  wire logic       clk,             // 250 MHz system clock
   input  wire logic       rst_n,           // async reset, active low
   input  wire logic       ce,              // clock enable, freezes state
   input  wire logic       strobe_n,        // serial frame strobe, active low
   input  wire logic       sclk,            // serial clock from host
   input  wire logic       sdi,             // serial data in
   output logic            sdo,             // serial data out
   output logic            sdo_oe_n,        // sdo drive enable, active low
   input  wire logic       logic_supply_over_flag,  // raw fault input
   input  wire logic       logic_supply_under_flag, // raw fault input
   input  wire logic       b_high_gate_under_flag,  // raw fault input
   input  wire logic       b_low_gate_under_flag,   // raw fault input
   input  wire logic       a_high_gate_under_flag,  // raw fault input
   input  wire logic       a_low_gate_under_flag,   // raw fault input
   input  wire logic       regulator_over_flag,     // raw fault input
   input  wire logic       regulator_under_flag,    // raw fault input
   input  wire logic       b_high_drain_over_flag,  // raw fault input
   input  wire logic       b_low_drain_over_flag,   // raw fault input
   input  wire logic       a_high_drain_over_flag,  // raw fault input
   input  wire logic       a_low_drain_over_flag,   // raw fault input
   input  wire logic       battery_over_flag,       // raw fault input
   input  wire logic       battery_under_flag,      // raw fault input
   input  wire logic       b_boot_under_flag,       // raw fault input
   input  wire logic       a_boot_under_flag,       // raw fault input
   input  wire logic       b_overcurrent_flag,      // raw fault input
   input  wire logic       a_overcurrent_flag,      // raw fault input
   input  wire logic       open_load_flag,          // raw fault input
   input  wire logic       overtemp_flag,           // raw overtemperature
   input  wire logic       temp_warning_flag,       // raw temperature warning
   input  wire logic       logic_over_flag,         // raw logic overvoltage
   input  wire logic       enable_watchdog_timeout_flag, // raw watchdog timeout
   input  wire logic       temp_sig,        // temperature signal for diag pin
   input  wire logic       sense_sig,       // sense amp signal for diag pin
   input  wire logic       a_high_in,       // phase a high input, active high
   input  wire logic       a_low_in_n,      // phase a low input, active low
   input  wire logic       b_high_in_n,     // phase b high input, active low
   input  wire logic       b_low_in,        // phase b low input, active high
   input  wire logic [7:0] dead_cyc,        // dead time in clock cycles
   output logic            diag_out,        // diagnostic pin
   output logic            boot_manager_off,// bootstrap manager disable
   output logic            a_high_gate,     // phase a high-side gate
   output logic            a_low_gate,      // phase a low-side gate
   output logic            b_high_gate,     // phase b high-side gate
   output logic            b_low_gate       // phase b low-side gate
);
   localparam int NSYNC = 32;

   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;
   logic [15:0]      d0_set;
   logic [15:0]      d1_set;
   logic [15:0]      d2_set;
   logic [15:0]      d0_r;
   logic [15:0]      d1_r;
   logic [15:0]      d2_r;
   logic [15:0]      ctrl_r;
   logic [15:0]      status_w;
   logic [15:0]      rx_r;
   logic [15:0]      tx_r;
   logic [4:0]       bit_cnt_r;
   logic [3:0]       reply_sel_r;
   logic             reply_stat_r;
   logic             por_r;
   logic             se_r;
   logic             sclk_d_r;
   logic             strb_d_r;
   logic             s_strb_n;
   logic             s_sclk;
   logic             s_sdi;
   logic             frame_start;
   logic             frame_end;
   logic             sclk_rise;
   logic             sclk_fall;
   logic             frame_ok;
   logic             wr_ctrl;
   logic             rd_req;
   logic [3:0]       rx_addr;
   logic             any_fault;
   logic             stop_bridge;
   logic [`BDRV_PCNT_W-1:0] pulse_cnt_r;
   logic             pulse_r;
   bdrv_pkg::bdrv_dgsel_t dg_sel;

   // odd parity over the upper fifteen bits
   function automatic logic odd_par(input logic [15:0] w);
      odd_par = ~(^w[15:1]);
   endfunction : odd_par

   function automatic logic [15:0] with_par(input logic [15:0] w);
      with_par = {w[15:1], odd_par(w)};
   endfunction : with_par

   assign raw_in = {sense_sig, temp_sig, enable_watchdog_timeout_flag, logic_over_flag,
                    temp_warning_flag, overtemp_flag, open_load_flag, a_overcurrent_flag,
                    b_overcurrent_flag, a_boot_under_flag, b_boot_under_flag, battery_under_flag,
                    battery_over_flag, a_low_drain_over_flag, a_high_drain_over_flag,
                    b_low_drain_over_flag, b_high_drain_over_flag, regulator_under_flag,
                    regulator_over_flag, a_low_gate_under_flag, a_high_gate_under_flag,
                    b_low_gate_under_flag, b_high_gate_under_flag,
                    logic_supply_under_flag, logic_supply_over_flag,
                    b_low_in, b_high_in_n, a_low_in_n, a_high_in, sdi, sclk, strobe_n};

   // frame strobe and bridge inputs idle high where the pin is active low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 32'h00000031;
         sync_r <= 32'h00000031;
      end else if (ce) begin
         meta_r <= raw_in;
         sync_r <= meta_r;
      end
   end

   assign s_strb_n = sync_r[0];
   assign s_sclk   = sync_r[1];
   assign s_sdi    = sync_r[2];

   // diag images, fields at the printed positions
   always_comb begin
      d0_set = 16'h0000;
      d1_set = 16'h0000;
      d2_set = 16'h0000;
      d0_set[`BDRV_D0_V3O] = sync_r[7];
      d0_set[`BDRV_D0_V3U] = sync_r[8];
      d0_set[`BDRV_D0_BHU] = sync_r[9];
      d0_set[`BDRV_D0_BLU] = sync_r[10];
      d0_set[`BDRV_D0_AHU] = sync_r[11];
      d0_set[`BDRV_D0_ALU] = sync_r[12];
      d1_set[`BDRV_D1_VRO] = sync_r[13];
      d1_set[`BDRV_D1_VRU] = sync_r[14];
      d1_set[`BDRV_D1_BHO] = sync_r[15];
      d1_set[`BDRV_D1_BLO] = sync_r[16];
      d1_set[`BDRV_D1_AHO] = sync_r[17];
      d1_set[`BDRV_D1_ALO] = sync_r[18];
      d2_set[`BDRV_D2_VSO] = sync_r[19];
      d2_set[`BDRV_D2_VSU] = sync_r[20];
      d2_set[`BDRV_D2_VB]  = sync_r[21];
      d2_set[`BDRV_D2_VA]  = sync_r[22];
      d2_set[`BDRV_D2_OCB] = sync_r[23];
      d2_set[`BDRV_D2_OCA] = sync_r[24];
      d2_set[`BDRV_D2_OL]  = sync_r[25];
   end

   // edges of the synchronised serial pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         strb_d_r <= 1'b1;
      end else if (ce) begin
         sclk_d_r <= s_sclk;
         strb_d_r <= s_strb_n;
      end
   end

   assign frame_start = strb_d_r && !s_strb_n;
   assign frame_end   = !strb_d_r && s_strb_n;
   assign sclk_rise   = !s_strb_n && s_sclk && !sclk_d_r;
   assign sclk_fall   = !s_strb_n && !s_sclk && sclk_d_r;

   // a frame counts only with exactly sixteen clocks and odd parity
   assign frame_ok = frame_end && (bit_cnt_r == `BDRV_FRAME_BITS)
                     && (rx_r[0] == odd_par(rx_r));
   assign rx_addr  = rx_r[`BDRV_ADDR_MSB:`BDRV_ADDR_LSB];
   assign wr_ctrl  = frame_ok && rx_r[`BDRV_WR_BIT] && (rx_addr == `BDRV_ADDR_CTRL);
   assign rd_req   = frame_ok && !rx_r[`BDRV_WR_BIT];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_r      <= 16'h0000;
         bit_cnt_r <= 5'h00;
      end else if (ce) begin
         if (frame_start) begin
            bit_cnt_r <= 5'h00;
         end else if (sclk_rise) begin
            rx_r <= {rx_r[14:0], s_sdi};
            if (bit_cnt_r != 5'h1F) bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // hardware sets win over the read clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         d0_r <= 16'h0000;
         d1_r <= 16'h0000;
         d2_r <= 16'h0000;
      end else if (ce) begin
         d0_r <= ((rd_req && rx_addr == `BDRV_ADDR_DIAG0) ? 16'h0000 : d0_r) | d0_set;
         d1_r <= ((rd_req && rx_addr == `BDRV_ADDR_DIAG1) ? 16'h0000 : d1_r) | d1_set;
         d2_r <= ((rd_req && rx_addr == `BDRV_ADDR_DIAG2) ? 16'h0000 : d2_r) | d2_set;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `BDRV_CTRL_RST;
      end else if (ce && wr_ctrl) begin
         ctrl_r <= rx_r & `BDRV_CTRL_MASK;
      end
   end

   // power-on and serial error flags clear once a good frame has carried them out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         por_r <= 1'b1;
         se_r  <= 1'b0;
      end else if (ce) begin
         if (frame_end && !frame_ok) se_r <= 1'b1;
         else if (frame_ok && reply_stat_r) se_r <= 1'b0;
         if (frame_ok && reply_stat_r) por_r <= 1'b0;
      end
   end

   assign any_fault = (|d0_r) || (|d1_r) || (|d2_r);

   always_comb begin
      status_w = 16'h0000;
      status_w[`BDRV_ST_FF]  = any_fault | por_r;
      status_w[`BDRV_ST_POR] = por_r;
      status_w[`BDRV_ST_SE]  = se_r;
      status_w[`BDRV_ST_OT]  = sync_r[26];
      status_w[`BDRV_ST_TW]  = sync_r[27];
      status_w[`BDRV_ST_VS]  = d2_r[`BDRV_D2_VSO] | d2_r[`BDRV_D2_VSU];
      status_w[`BDRV_ST_VLO] = sync_r[28];
      status_w[`BDRV_ST_ETO] = sync_r[29];
      status_w[`BDRV_ST_VR]  = d1_r[`BDRV_D1_VRO] | d1_r[`BDRV_D1_VRU];
      status_w[`BDRV_ST_V3]  = d0_r[`BDRV_D0_V3O] | d0_r[`BDRV_D0_V3U];
      status_w[`BDRV_ST_LDF] = d2_r[`BDRV_D2_OCA] | d2_r[`BDRV_D2_OCB]
                               | d2_r[`BDRV_D2_OL];
      status_w[`BDRV_ST_BSU] = d2_r[`BDRV_D2_VA] | d2_r[`BDRV_D2_VB];
      status_w[`BDRV_ST_GSU] = d0_r[`BDRV_D0_BHU] | d0_r[`BDRV_D0_BLU]
                               | d0_r[`BDRV_D0_AHU] | d0_r[`BDRV_D0_ALU];
      status_w[`BDRV_ST_DSO] = d1_r[`BDRV_D1_BHO] | d1_r[`BDRV_D1_BLO]
                               | d1_r[`BDRV_D1_AHO] | d1_r[`BDRV_D1_ALO];
   end

   // a good read of address C to F turns the next reply into that register, else status goes out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reply_sel_r <= `BDRV_ADDR_NONE;
      end else if (ce && frame_end) begin
         if (rd_req && rx_addr >= `BDRV_ADDR_DIAG0) reply_sel_r <= rx_addr;
         else reply_sel_r <= `BDRV_ADDR_NONE;
      end
   end

   // reply is frozen at strobe fall; sdo moves on the falling serial clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_r         <= 16'h0000;
         reply_stat_r <= 1'b0;
      end else if (ce) begin
         if (frame_start) begin
            reply_stat_r <= (reply_sel_r == `BDRV_ADDR_NONE);
            case (reply_sel_r)
               `BDRV_ADDR_DIAG0: tx_r <= with_par({`BDRV_ADDR_DIAG0, d0_r[11:0]});
               `BDRV_ADDR_DIAG1: tx_r <= with_par({`BDRV_ADDR_DIAG1, d1_r[11:0]});
               `BDRV_ADDR_DIAG2: tx_r <= with_par({`BDRV_ADDR_DIAG2, d2_r[11:0]});
               `BDRV_ADDR_CTRL:  tx_r <= with_par({`BDRV_ADDR_CTRL, ctrl_r[11:0]});
               default:          tx_r <= with_par(status_w);
            endcase
         end else if (sclk_fall && bit_cnt_r != 5'h00) begin
            tx_r <= {tx_r[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdo      <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else if (ce) begin
         sdo      <= tx_r[15];
         sdo_oe_n <= s_strb_n;
      end
   end

   // pulsed fault mode toggles while any fault is held
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_r <= '0;
         pulse_r     <= 1'b0;
      end else if (ce) begin
         if (!any_fault) begin
            pulse_cnt_r <= '0;
            pulse_r     <= 1'b0;
         end else if (pulse_cnt_r == `BDRV_PCNT_W'(`BDRV_PULSE_CYC - 1)) begin
            pulse_cnt_r <= '0;
            pulse_r     <= !pulse_r;
         end else begin
            pulse_cnt_r <= pulse_cnt_r + `BDRV_PCNT_W'(1);
         end
      end
   end

   assign dg_sel = bdrv_pkg::bdrv_dgsel_t'(ctrl_r[`BDRV_DG_MSB:`BDRV_DG_LSB]);

   // inside a frame the pin falls back to the plain fault level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_out <= 1'b1;
      end else if (ce) begin
         if (!s_strb_n) begin
            diag_out <= !any_fault;
         end else begin
            case (dg_sel)
               bdrv_pkg::BDRV_DG_FAULT: diag_out <= !any_fault;
               bdrv_pkg::BDRV_DG_PULSE: diag_out <= pulse_r;
               bdrv_pkg::BDRV_DG_TEMP:  diag_out <= sync_r[30];
               bdrv_pkg::BDRV_DG_SENSE: diag_out <= sync_r[31];
               default:                 diag_out <= !any_fault;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) boot_manager_off <= 1'b0;
      else if (ce) boot_manager_off <= ctrl_r[`BDRV_DBM_BIT];
   end

   assign stop_bridge = ctrl_r[`BDRV_ESF_BIT] && any_fault;

   // pin polarities let one pwm line drive the whole bridge in fast decay
   logic a_hi_req;
   logic a_lo_req;
   logic b_hi_req;
   logic b_lo_req;
   assign a_hi_req = !stop_bridge && (sync_r[3] || ctrl_r[`BDRV_AH_BIT]);
   assign a_lo_req = !stop_bridge && (!sync_r[4] || ctrl_r[`BDRV_AL_BIT]);
   assign b_hi_req = !stop_bridge && (!sync_r[5] || ctrl_r[`BDRV_BH_BIT]);
   assign b_lo_req = !stop_bridge && (sync_r[6] || ctrl_r[`BDRV_BL_BIT]);

   bdrv_deadtime u_phase_a (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .hi_req   (a_hi_req),
      .lo_req   (a_lo_req),
      .dead_cyc (dead_cyc),
      .hi_gate  (a_high_gate),
      .lo_gate  (a_low_gate)
   );

   bdrv_deadtime u_phase_b (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .hi_req   (b_hi_req),
      .lo_req   (b_lo_req),
      .dead_cyc (dead_cyc),
      .hi_gate  (b_high_gate),
      .lo_gate  (b_low_gate)
   );
endmodule : bdrv_regs

// file: bdrv_regs_monitor.sv
// Purpose: port checks of bdrv_regs
// Assumes: dead time judged at dead_cyc of 4
// Notes: bind at the foot
`timescale 1ns/1ps
module bdrv_regs_monitor (
   input wire logic       clk,              // clock
   input wire logic       rst_n,            // reset
   input wire logic       strobe_n,         // strobe
   input wire logic       sdo_oe_n,         // out enable
   input wire logic [7:0] dead_cyc,         // dead time
   input wire logic       boot_manager_off, // boot off
   input wire logic       a_high_gate,      // gate
   input wire logic       a_low_gate,       // gate
   input wire logic       b_high_gate,      // gate
   input wire logic       b_low_gate        // gate
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence in_frame; (!strobe_n) [*5]; endsequence
   a_overlap_a: assert property (!(a_high_gate && a_low_gate)) else $error("a overlap");
   b_overlap_a: assert property (!(b_high_gate && b_low_gate)) else $error("b overlap");
   a_dead_a: assert property (($fell(a_high_gate) || $fell(a_low_gate)) && dead_cyc == 8'h04
      |-> !(a_high_gate || a_low_gate) [*4]) else $error("a dead time");
   b_dead_a: assert property (($fell(b_high_gate) || $fell(b_low_gate)) && dead_cyc == 8'h04
      |-> !(b_high_gate || b_low_gate) [*4]) else $error("b dead time");
   reset_out_a: assert property ($rose(rst_n) |-> sdo_oe_n && !boot_manager_off
      && !(a_high_gate || a_low_gate || b_high_gate || b_low_gate)) else $error("reset out");
   oe_idle_a: assert property (strobe_n [*4] |-> sdo_oe_n) else $error("oe idle");
   oe_drive_a: assert property (in_frame |-> !sdo_oe_n) else $error("oe drive");
   boot_hold_a: assert property (in_frame |=> $stable(boot_manager_off)) else $error("boot");
endmodule : bdrv_regs_monitor
bind bdrv_regs bdrv_regs_monitor mon (.clk(clk), .rst_n(rst_n), .strobe_n(strobe_n),
   .sdo_oe_n(sdo_oe_n), .dead_cyc(dead_cyc), .boot_manager_off(boot_manager_off),
   .a_high_gate(a_high_gate), .a_low_gate(a_low_gate), .b_high_gate(b_high_gate),
   .b_low_gate(b_low_gate));

// file: bdrv_host.sv
// Purpose: serial host model for bdrv_regs
// Assumes: mode 0, msb first, 8 clk per sclk phase
// Notes: sdi shows its inverse between frames
`timescale 1ns/1ps
module bdrv_host (
   input  wire logic clk,             // clock
   input  wire logic sdo,             // device data
   output logic      strobe_n = 1'b1, // frame strobe
   output logic      sclk = 1'b0,     // serial clock
   output logic      sdi = 1'b0       // host data
);
   // caller supplies the parity bit, so bad frames can be sent on purpose
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      @(negedge clk);
      strobe_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         repeat (8) @(negedge clk);
         sclk = 1'b1;
         r[i] = sdo;
         repeat (8) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      strobe_n = 1'b1;
      sdi = ~sdi;
      repeat (16) @(negedge clk);
   endtask : xfer
endmodule : bdrv_host

// file: tb_bridge_driver_diag_control_regs.sv
// Purpose: self-checking bench of bdrv_regs
// Assumes: host model bdrv_host, dead_cyc of 4
// Notes: a read reply arrives one frame late
`timescale 1ns/1ps
module tb_bridge_driver_diag_control_regs;
   logic        clk = 1'b0, rst_n = 1'b0, temp_sig = 1'b0, sense_sig = 1'b1;
   logic        strobe_n, sclk, sdi, sdo, sdo_oe_n, diag_out, boot_manager_off, dg;
   logic [3:0]  pin = 4'b0110, gates;
   logic [22:0] flt = '0;
   int          failures, checked;
   bdrv_host host (.clk, .sdo, .strobe_n, .sclk, .sdi);
   bdrv_regs dut (.clk, .rst_n, .ce(1'b1), .strobe_n, .sclk, .sdi, .sdo, .sdo_oe_n,
      .logic_supply_over_flag(flt[0]), .logic_supply_under_flag(flt[1]),
      .b_high_gate_under_flag(flt[2]), .b_low_gate_under_flag(flt[3]),
      .a_high_gate_under_flag(flt[4]), .a_low_gate_under_flag(flt[5]),
      .regulator_over_flag(flt[6]), .regulator_under_flag(flt[7]),
      .b_high_drain_over_flag(flt[8]), .b_low_drain_over_flag(flt[9]),
      .a_high_drain_over_flag(flt[10]), .a_low_drain_over_flag(flt[11]),
      .battery_over_flag(flt[12]), .battery_under_flag(flt[13]), .b_boot_under_flag(flt[14]),
      .a_boot_under_flag(flt[15]), .b_overcurrent_flag(flt[16]), .a_overcurrent_flag(flt[17]),
      .open_load_flag(flt[18]), .overtemp_flag(flt[19]), .temp_warning_flag(flt[20]),
      .logic_over_flag(flt[21]), .enable_watchdog_timeout_flag(flt[22]), .temp_sig, .sense_sig,
      .a_high_in(pin[3]), .a_low_in_n(pin[2]), .b_high_in_n(pin[1]), .b_low_in(pin[0]),
      .dead_cyc(8'h04), .diag_out, .boot_manager_off, .a_high_gate(gates[3]),
      .a_low_gate(gates[2]), .b_high_gate(gates[1]), .b_low_gate(gates[0]));
   task automatic chk(input logic [15:0] g, e);
      checked++;
      if (g !== e) $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      if (g !== e) failures++;
   endtask : chk
   task automatic xf(input logic [15:0] w, e);
      logic [15:0] r;
      host.xfer(w, r);
      chk(r, e);
      chk({15'h0000, ^r}, 16'h0001);
   endtask : xf
   task tally_and_finish;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial forever #2 clk = ~clk;
   initial begin
      #100us;
      failures++;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk({11'h000, boot_manager_off, gates}, 16'h0000);
      xf(16'h0001, 16'hC001);
      xf(16'h0000, 16'h0001);
      xf(16'hF904, 16'h2000);
      xf(16'hF001, 16'h0001);
      xf(16'h0001, 16'hF105);
      repeat (24) @(negedge clk);
      chk({11'h000, boot_manager_off, gates}, 16'h0018);
      xf(16'hF881, 16'h0001);
      $display("serial test done");
      pin = 4'b1111;
      repeat (24) @(negedge clk);
      chk({12'h000, gates}, 16'h0009);
      pin = 4'b0000;
      repeat (24) @(negedge clk);
      chk({12'h000, gates}, 16'h0006);
      xf(16'hFC80, 16'h0001);
      chk({15'h0000, diag_out}, 16'h0000);
      xf(16'hFE81, 16'h0001);
      chk({15'h0000, diag_out}, 16'h0001);
      xf(16'hF881, 16'h0001);
      chk({15'h0000, diag_out}, 16'h0001);
      $display("bridge test done");
      pin = 4'b1111;
      flt = '1;
      repeat (24) @(negedge clk);
      chk({11'h000, diag_out, gates}, 16'h0000);
      xf(16'hC001, 16'h8FFF);
      xf(16'hD000, 16'hC61F);
      xf(16'hE000, 16'hD61E);
      xf(16'h0001, 16'hE6CF);
      xf(16'hFA80, 16'h8FFF);
      dg = diag_out;
      repeat (250) @(negedge clk);
      chk({15'h0000, diag_out}, {15'h0000, ~dg});
      $display("fault test done");
      tally_and_finish;
   end
endmodule : tb_bridge_driver_diag_control_regs
